// [dv/prl_far_model.sv]
// Behavioural peripherals and pads on the far side of the pin router.
module prl_far_model
  import prl_pkg::*;
(
  input wire logic clk_i,
  input wire logic [DEF_NUM_PINS-1:0] drv_i,
  input wire logic [DEF_NUM_PINS-1:0] drv_oe_i,
  output logic [DEF_NUM_PINS-1:0] pin_o,
  output logic [DEF_NUM_PINS-1:0] port_data_o,
  output logic [DEF_NUM_PINS-1:0] port_oe_o,
  output logic [DEF_NUM_OUT-1:0] periph_out_o,
  output logic [DEF_NUM_OUT-1:0] periph_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pat_ff = 8'hA5;
  // Idle pads and peripherals move every cycle, so a stale routing cannot match by luck.
  always @(posedge clk_i) pat_ff <= {pat_ff[6:0], pat_ff[7] ^ pat_ff[5] ^ pat_ff[4] ^ pat_ff[3]};
  // A pad driven by the router shows that level; an undriven pad shows the inverted pattern.
  assign pin_o = (drv_oe_i & drv_i) | (~drv_oe_i & ~pat_ff);
  assign port_data_o = pat_ff;
  assign port_oe_o = {pat_ff[3:0], pat_ff[7:4]};
  assign periph_out_o = pat_ff[3:0] ^ pat_ff[7:4];
  assign periph_oe_o = pat_ff[6:3];
endmodule : prl_far_model

// [dv/prl_router_test.sv]
// Self-checking bench for the pin router and its lock sequencer.
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module prl_router_test
  import prl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, sys_rst_i = 1, warm_rst_i = 0, sleep_i = 0, one_shot_lock_cfg_i = 0;
  logic lock_wr_i = 0, lock_bset_i = 0, lock_bclr_i = 0, ext_wr_i = 0, sel_wr_i = 0;
  logic sel_dir_i = 0;
  logic [7:0] lock_wdata_i = 8'h00;
  logic [2:0] lock_bit_i = 3'h0;
  logic [3:0] sel_idx_i = 4'h0, sel_val_i = 4'h0;
  logic [7:0] pin_i, port_data_i, port_oe_i, pin_o, pin_oe_o, s_pin, s_pd, s_poe;
  logic [3:0] periph_out_i, periph_oe_i, periph_in_o, s_po, s_pe;
  logic routing_locked_flag_o, one_shot_used_o, exp_lock, exp_used;
  int exp_in[4];
  int exp_out[8];
  int fails = 0;
  int cmp_count = 0;

  prl_router dut_u (.clk_i, .sys_rst_i, .warm_rst_i, .sleep_i, .one_shot_lock_cfg_i,
    .lock_wr_i, .lock_wdata_i, .lock_bset_i, .lock_bclr_i, .lock_bit_i, .ext_wr_i,
    .sel_wr_i, .sel_dir_i, .sel_idx_i, .sel_val_i, .pin_i, .port_data_i, .port_oe_i,
    .periph_out_i, .periph_oe_i, .periph_in_o, .pin_o, .pin_oe_o, .routing_locked_flag_o,
    .one_shot_used_o);
  prl_far_model far_u (.clk_i, .drv_i(pin_o), .drv_oe_i(pin_oe_o), .pin_o(pin_i),
    .port_data_o(port_data_i), .port_oe_o(port_oe_i), .periph_out_o(periph_out_i),
    .periph_oe_o(periph_oe_i));

  always #25 clk_i = ~clk_i;

  // ****************************************************************
  // Shared drivers and comparison
  // ****************************************************************
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic set_defaults();
    for (int i = 0; i < 4; i++) exp_in[i] = i;
    for (int p = 0; p < 8; p++) exp_out[p] = 0;
    exp_lock = 0;
    exp_used = 0;
  endtask : set_defaults

  // Snapshot the far side before an edge, then judge what the router made of it.
  task automatic check_paths();
    logic [7:0] ep, eo;
    logic [3:0] ei;
    @(negedge clk_i);
    s_pin = pin_i;
    s_pd = port_data_i;
    s_poe = port_oe_i;
    s_po = periph_out_i;
    s_pe = periph_oe_i;
    step();
    for (int p = 0; p < 8; p++) begin
      ep[p] = exp_out[p] == 0 ? s_pd[p] : s_po[exp_out[p]-1];
      eo[p] = exp_out[p] == 0 ? s_poe[p] : s_pe[exp_out[p]-1];
    end
    for (int i = 0; i < 4; i++) ei[i] = s_pin[exp_in[i]];
    `CHK("pin_o", ep, pin_o)
    `CHK("pin_oe_o", eo, pin_oe_o)
    `CHK("periph_in_o", ei, periph_in_o)
    `CHK("locked", exp_lock, routing_locked_flag_o)
    `CHK("one_shot_used", exp_used, one_shot_used_o)
  endtask : check_paths

  task automatic sel_wr(input logic dir, input int idx, input int val);
    sel_wr_i = 1;
    sel_dir_i = dir;
    sel_idx_i = 4'(idx);
    sel_val_i = 4'(val);
    step();
    sel_wr_i = 0;
    step();
    if (!exp_lock && !warm_rst_i) begin
      if (dir == SEL_DIR_IN && val < 8) exp_in[idx] = val;
      if (dir == SEL_DIR_OUT && val <= 4) exp_out[idx] = val;
    end
  endtask : sel_wr

  // Kind 0 writes byte d, kind 1 sets and kind 2 clears bit d.
  task automatic lk(input int kind, input logic [7:0] d);
    lock_wr_i = kind == 0;
    lock_bset_i = kind == 1;
    lock_bclr_i = kind == 2;
    lock_wdata_i = d;
    lock_bit_i = d[2:0];
    step();
    lock_wr_i = 0;
    lock_bset_i = 0;
    lock_bclr_i = 0;
    // An idle edge between accesses keeps the strobes from being rewritten in one time step.
    step();
  endtask : lk

  task automatic seq(input int kind, input logic [7:0] b);
    lk(0, 8'h55);
    lk(0, 8'hAA);
    lk(kind, b);
  endtask : seq

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_routing();
    check_paths();
    for (int p = 0; p < 8; p++) sel_wr(SEL_DIR_OUT, p, p % 5);
    for (int i = 0; i < 4; i++) sel_wr(SEL_DIR_IN, i, 7 - i);
    sel_wr(SEL_DIR_OUT, 1, 5);
    sel_wr(SEL_DIR_IN, 0, 8);
    sel_wr(SEL_DIR_IN, 2, 3);
    sel_wr(SEL_DIR_OUT, 3, 2);
    check_paths();
  endtask : t_routing

  task automatic t_lock();
    seq(0, 8'h01);
    check_paths();
    seq(1, 8'h01);
    check_paths();
    lk(1, 8'h00);
    check_paths();
    seq(1, 8'h00);
    exp_lock = 1;
    check_paths();
    sel_wr(SEL_DIR_OUT, 0, 4);
    sel_wr(SEL_DIR_IN, 1, 0);
    check_paths();
    lk(0, 8'h55);
    ext_wr_i = 1;
    step();
    ext_wr_i = 0;
    lk(0, 8'hAA);
    lk(2, 8'h00);
    check_paths();
    lk(0, 8'h55);
    sel_wr(SEL_DIR_OUT, 0, 4);
    lk(0, 8'hAA);
    lk(2, 8'h00);
    check_paths();
    lk(0, 8'hAA);
    lk(0, 8'h55);
    lk(2, 8'h00);
    check_paths();
    seq(2, 8'h00);
    exp_lock = 0;
    check_paths();
  endtask : t_lock

  task automatic t_sleep_warm();
    sleep_i = 1;
    check_paths();
    sel_wr(SEL_DIR_OUT, 5, 1);
    sleep_i = 0;
    check_paths();
    seq(1, 8'h00);
    exp_lock = 1;
    warm_rst_i = 1;
    check_paths();
    warm_rst_i = 0;
    lk(0, 8'h55);
    lk(0, 8'hAA);
    warm_rst_i = 1;
    step();
    warm_rst_i = 0;
    lk(2, 8'h00);
    check_paths();
    seq(2, 8'h00);
    exp_lock = 0;
    warm_rst_i = 1;
    sel_wr(SEL_DIR_OUT, 6, 2);
    warm_rst_i = 0;
    check_paths();
  endtask : t_sleep_warm

  task automatic t_one_shot();
    one_shot_lock_cfg_i = 1;
    seq(1, 8'h00);
    exp_lock = 1;
    check_paths();
    seq(2, 8'h00);
    exp_lock = 0;
    exp_used = 1;
    sel_wr(SEL_DIR_IN, 3, 6);
    seq(1, 8'h00);
    exp_lock = 1;
    check_paths();
    seq(2, 8'h00);
    warm_rst_i = 1;
    check_paths();
    warm_rst_i = 0;
    sys_rst_i = 1;
    step();
    sys_rst_i = 0;
    `CHK("rst_oe", 8'h00, pin_oe_o)
    `CHK("rst_pin", 8'h00, pin_o)
    `CHK("rst_in", 4'h0, periph_in_o)
    set_defaults();
    step();
    check_paths();
    seq(1, 8'h00);
    seq(2, 8'h00);
    exp_used = 1;
    check_paths();
  endtask : t_one_shot

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic conclude();
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // The whole run needs under two hundred cycles; two thousand leaves ample margin.
  initial begin
    #100000;
    fails++;
    conclude();
  end

  initial begin
    set_defaults();
    repeat (8) @(posedge clk_i);
    #1;
    sys_rst_i = 0;
    step();
    t_routing();
    t_lock();
    t_sleep_warm();
    t_one_shot();
    conclude();
  end
endmodule : prl_router_test

// [pkg/prl_pkg.sv]
// Constants and types shared by the pin router and its lock sequencer.
// Functional notes
// - While locked, every input and output routing write is ignored.
// - Lock bit changes only right after consecutive 55h then AAh lock writes.
// - Lock flag is bit 0, changed only by single-bit set or clear.
// - With one-shot config, one clear and one set allowed; then stays set.
// - Sleep entry or exit never alters any routing selection.
// - Power-on reset restores default routing; other resets keep selections.
// - Power-on reset also clears the recorded one-shot lock state.
package prl_pkg;

  // ****************************************************************
  // Lock register encoding
  // ****************************************************************
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
  localparam logic [2:0] LOCK_FLAG_POS = 3'h0;
  localparam logic LOCK_FLAG_RST = 1'h0;
  localparam logic ONE_SHOT_USED_RST = 1'h0;

  // ****************************************************************
  // Routing selection layout
  // ****************************************************************
  localparam int SEL_W = 4;
  localparam int MAX_PORTS = 16;
  localparam int DEF_NUM_PINS = 8;
  localparam int DEF_NUM_IN = 4;
  localparam int DEF_NUM_OUT = 4;
  localparam logic [SEL_W-1:0] OUT_SEL_PORT = 4'h0;
  localparam logic SEL_DIR_IN = 1'h0;
  localparam logic SEL_DIR_OUT = 1'h1;

  typedef enum logic [1:0] {
    PRL_IDLE,
    PRL_GOT_FIRST,
    PRL_ARMED
  } prl_key_state_t;

endpackage : prl_pkg

// [verilog/prl_lock_seq.sv]
// Unlock pattern detector, lock flag and one-shot lock record.
module prl_lock_seq
  import prl_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic warm_rst_i,
  input wire logic lock_wr_i,
  input wire logic [7:0] lock_wdata_i,
  input wire logic lock_bset_i,
  input wire logic lock_bclr_i,
  input wire logic [2:0] lock_bit_i,
  input wire logic other_wr_i,
  input wire logic one_shot_lock_cfg_i,
  output logic routing_locked_flag_o,
  output logic one_shot_used_o
);

  prl_key_state_t state_ff, nxt_state;
  logic locked_ff, nxt_locked;
  logic used_ff, nxt_used;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_locked = locked_ff;
    nxt_used = used_ff;
    if (warm_rst_i || other_wr_i) begin
      nxt_state = PRL_IDLE;
    end else if (lock_wr_i) begin
      // A whole-byte write only advances the key; it never moves the flag.
      case (state_ff)
        PRL_IDLE: begin
          nxt_state = (lock_wdata_i == UNLOCK_KEY_FIRST) ? PRL_GOT_FIRST : PRL_IDLE;
        end
        PRL_GOT_FIRST: begin
          if (lock_wdata_i == UNLOCK_KEY_SECOND) begin
            nxt_state = PRL_ARMED;
          end else if (lock_wdata_i == UNLOCK_KEY_FIRST) begin
            nxt_state = PRL_GOT_FIRST;
          end else begin
            nxt_state = PRL_IDLE;
          end
        end
        PRL_ARMED: begin
          nxt_state = (lock_wdata_i == UNLOCK_KEY_FIRST) ? PRL_GOT_FIRST : PRL_IDLE;
        end
        default: begin
          nxt_state = PRL_IDLE;
        end
      endcase
    end else if (lock_bset_i || lock_bclr_i) begin
      nxt_state = PRL_IDLE;
      if (state_ff == PRL_ARMED && lock_bit_i == LOCK_FLAG_POS) begin
        if (lock_bset_i) begin
          nxt_locked = 1'b1;
        end else if (!(one_shot_lock_cfg_i && used_ff)) begin
          nxt_locked = 1'b0;
          nxt_used = used_ff | one_shot_lock_cfg_i;
        end
      end
    end
  end

  // Only power-on reset forgets the one-shot record, so a warm reset cannot reopen it.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= PRL_IDLE;
      locked_ff <= LOCK_FLAG_RST;
      used_ff <= ONE_SHOT_USED_RST;
    end else begin
      state_ff <= nxt_state;
      locked_ff <= nxt_locked;
      used_ff <= nxt_used;
    end
  end

  assign routing_locked_flag_o = locked_ff;
  assign one_shot_used_o = used_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking

  a_flag_needs_key: assert property (
    disable iff (sys_rst_i) (state_ff != PRL_ARMED) |=> $stable(locked_ff))
    else $error("lock flag moved without the unlock pattern");
  a_key_sequence: assert property (
    disable iff (sys_rst_i)
    (state_ff == PRL_IDLE && lock_wr_i && !other_wr_i && !warm_rst_i
     && lock_wdata_i == UNLOCK_KEY_FIRST)
    ##1 (lock_wr_i && !other_wr_i && !warm_rst_i && lock_wdata_i == UNLOCK_KEY_SECOND)
    |=> state_ff == PRL_ARMED)
    else $error("55h then AAh did not arm the lock");
  a_byte_no_flag: assert property (
    disable iff (sys_rst_i) lock_wr_i |=> $stable(locked_ff))
    else $error("byte write changed the lock flag");
  a_one_shot_hold: assert property (
    disable iff (sys_rst_i) (one_shot_lock_cfg_i && used_ff && locked_ff) |=> locked_ff)
    else $error("one-shot lock was cleared a second time");
  a_por_clears_used: assert property (
    sys_rst_i |=> (!used_ff && !locked_ff))
    else $error("power-on reset left one-shot state");
  a_pattern_restart: assert property (
    disable iff (sys_rst_i) (other_wr_i || warm_rst_i) |=> state_ff == PRL_IDLE)
    else $error("intervening write did not restart the pattern");

  c_lock_set: cover property (disable iff (sys_rst_i) !locked_ff ##1 locked_ff);
  c_lock_clear: cover property (disable iff (sys_rst_i) locked_ff ##1 !locked_ff);
  c_one_shot_refused: cover property (
    disable iff (sys_rst_i) state_ff == PRL_ARMED && lock_bclr_i && used_ff && locked_ff);

endmodule : prl_lock_seq

// [verilog/prl_router.sv]
// Peripheral-to-pin router with lockable input and output routing selections.
module prl_router
  import prl_pkg::*;
#(
  parameter int NUM_PINS = DEF_NUM_PINS,
  parameter int NUM_IN = DEF_NUM_IN,
  parameter int NUM_OUT = DEF_NUM_OUT
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic warm_rst_i,
  input wire logic sleep_i,
  input wire logic one_shot_lock_cfg_i,
  input wire logic lock_wr_i,
  input wire logic [7:0] lock_wdata_i,
  input wire logic lock_bset_i,
  input wire logic lock_bclr_i,
  input wire logic [2:0] lock_bit_i,
  input wire logic ext_wr_i,
  input wire logic sel_wr_i,
  input wire logic sel_dir_i,
  input wire logic [SEL_W-1:0] sel_idx_i,
  input wire logic [SEL_W-1:0] sel_val_i,
  input wire logic [NUM_PINS-1:0] pin_i,
  input wire logic [NUM_PINS-1:0] port_data_i,
  input wire logic [NUM_PINS-1:0] port_oe_i,
  input wire logic [NUM_OUT-1:0] periph_out_i,
  input wire logic [NUM_OUT-1:0] periph_oe_i,
  output logic [NUM_IN-1:0] periph_in_o,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic routing_locked_flag_o,
  output logic one_shot_used_o
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Index value MAX_PORTS-1 must stay free so the padded vectors below are never empty.
  if (NUM_PINS < 2 || NUM_PINS >= MAX_PORTS || NUM_IN < 1 || NUM_IN >= MAX_PORTS
      || NUM_OUT < 1 || NUM_OUT >= MAX_PORTS - 1) begin : g_bad_params
    $error("prl_router: pin or peripheral count out of range");
  end

  typedef logic [NUM_IN-1:0][SEL_W-1:0] prl_in_sel_t;
  typedef logic [NUM_PINS-1:0][SEL_W-1:0] prl_out_sel_t;

  function automatic logic pick_bit(input logic [MAX_PORTS-1:0] vec,
                                    input logic [SEL_W-1:0] idx);
    pick_bit = vec[idx];
  endfunction : pick_bit

  function automatic prl_in_sel_t in_sel_default();
    prl_in_sel_t d;
    d = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      d[i] = SEL_W'(i % NUM_PINS);
    end
    in_sel_default = d;
  endfunction : in_sel_default

  localparam prl_in_sel_t IN_SEL_DEF = in_sel_default();
  localparam prl_out_sel_t OUT_SEL_DEF = '0;

  prl_in_sel_t in_sel_ff, nxt_in_sel;
  prl_out_sel_t out_sel_ff, nxt_out_sel;
  logic locked;
  logic sel_write_ok;

  // ****************************************************************
  // Lock sequencer
  // ****************************************************************
  prl_lock_seq u_lock (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .warm_rst_i(warm_rst_i),
    .lock_wr_i(lock_wr_i),
    .lock_wdata_i(lock_wdata_i),
    .lock_bset_i(lock_bset_i),
    .lock_bclr_i(lock_bclr_i),
    .lock_bit_i(lock_bit_i),
    .other_wr_i(ext_wr_i | sel_wr_i),
    .one_shot_lock_cfg_i(one_shot_lock_cfg_i),
    .routing_locked_flag_o(locked),
    .one_shot_used_o(one_shot_used_o)
  );

  assign routing_locked_flag_o = locked;

  // ****************************************************************
  // Routing selections
  // ****************************************************************
  // Sleep has no path into this logic; the selections are plain state.
  // A bidirectional peripheral needs its input and output routed to one pin;
  // nothing here enforces that pairing.
  // Out-of-range values are dropped rather than clipped, so a bad write keeps the old route.
  assign sel_write_ok = sel_wr_i && !locked && !warm_rst_i;

  always_comb begin
    nxt_in_sel = in_sel_ff;
    nxt_out_sel = out_sel_ff;
    if (sel_write_ok) begin
      if (sel_dir_i == SEL_DIR_IN) begin
        for (int i = 0; i < NUM_IN; i++) begin
          if (sel_idx_i == SEL_W'(i) && sel_val_i < SEL_W'(NUM_PINS)) begin
            nxt_in_sel[i] = sel_val_i;
          end
        end
      end else begin
        for (int p = 0; p < NUM_PINS; p++) begin
          if (sel_idx_i == SEL_W'(p) && sel_val_i <= SEL_W'(NUM_OUT)) begin
            nxt_out_sel[p] = sel_val_i;
          end
        end
      end
    end
  end

  // A warm reset falls through to the hold branch, keeping the selections.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_sel_ff <= IN_SEL_DEF;
      out_sel_ff <= OUT_SEL_DEF;
    end else begin
      in_sel_ff <= nxt_in_sel;
      out_sel_ff <= nxt_out_sel;
    end
  end

  // ****************************************************************
  // Signal muxing
  // ****************************************************************
  logic [NUM_IN-1:0] nxt_periph_in, periph_in_ff;
  logic [NUM_PINS-1:0] nxt_pin, pin_ff;
  logic [NUM_PINS-1:0] nxt_pin_oe, pin_oe_ff;
  logic [MAX_PORTS-1:0] pin_vec, out_vec, oe_vec;

  assign pin_vec = {{(MAX_PORTS-NUM_PINS){1'b0}}, pin_i};
  assign out_vec = {{(MAX_PORTS-NUM_OUT){1'b0}}, periph_out_i};
  assign oe_vec = {{(MAX_PORTS-NUM_OUT){1'b0}}, periph_oe_i};

  // Output selection 0 keeps a pin on its port; selection k picks peripheral output k-1.
  // Writes above the peripheral count are refused, so the minus one never wraps in use.
  // Registering the mux adds one cycle of latency but keeps every output on a flop.
  always_comb begin
    nxt_periph_in = '0;
    nxt_pin = '0;
    nxt_pin_oe = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      nxt_periph_in[i] = pick_bit(pin_vec, in_sel_ff[i]);
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      if (out_sel_ff[p] == OUT_SEL_PORT) begin
        nxt_pin[p] = port_data_i[p];
        nxt_pin_oe[p] = port_oe_i[p];
      end else begin
        nxt_pin[p] = pick_bit(out_vec, SEL_W'(out_sel_ff[p] - 1'b1));
        nxt_pin_oe[p] = pick_bit(oe_vec, SEL_W'(out_sel_ff[p] - 1'b1));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      periph_in_ff <= '0;
      pin_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      periph_in_ff <= nxt_periph_in;
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign periph_in_o = periph_in_ff;
  assign pin_o = pin_ff;
  assign pin_oe_o = pin_oe_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking

  a_locked_no_write: assert property (
    disable iff (sys_rst_i) (locked && sel_wr_i)
    |=> ($stable(in_sel_ff) && $stable(out_sel_ff)))
    else $error("routing changed while locked");
  a_sleep_hold: assert property (
    disable iff (sys_rst_i) ($changed(sleep_i) && !sel_wr_i)
    |=> ($stable(in_sel_ff) && $stable(out_sel_ff)))
    else $error("sleep transition altered routing");
  a_por_defaults: assert property (
    sys_rst_i |=> (in_sel_ff == IN_SEL_DEF && out_sel_ff == OUT_SEL_DEF))
    else $error("power-on reset did not restore routing");
  a_warm_keeps: assert property (
    disable iff (sys_rst_i) warm_rst_i |=> ($stable(in_sel_ff) && $stable(out_sel_ff)))
    else $error("warm reset altered routing");
  a_in_route_path: assert property (
    disable iff (sys_rst_i) (!sel_write_ok && in_sel_ff[0] < SEL_W'(NUM_PINS))
    |=> periph_in_o[0] == $past(pin_vec[in_sel_ff[0]]))
    else $error("peripheral input does not follow selected pin");

  // Pin 0 stays on its port and pin 1 sits on a peripheral through most of the bench, so one pin of each
  // kind stands for the rest; a pairing of input and output routes relies on both
  // paths following their selections.
  a_out_route_port: assert property (
    disable iff (sys_rst_i) (out_sel_ff[0] == OUT_SEL_PORT)
    |=> (pin_o[0] == $past(port_data_i[0]) && pin_oe_o[0] == $past(port_oe_i[0])))
    else $error("pin output does not follow its port");
  a_out_route_periph: assert property (
    disable iff (sys_rst_i) (out_sel_ff[1] != OUT_SEL_PORT && out_sel_ff[1] <= SEL_W'(NUM_OUT))
    |=> (pin_o[1] == $past(out_vec[out_sel_ff[1] - 1'b1])
         && pin_oe_o[1] == $past(oe_vec[out_sel_ff[1] - 1'b1])))
    else $error("pin output does not follow its peripheral");
  a_out_sel_lands: assert property (
    disable iff (sys_rst_i) (sel_write_ok && sel_dir_i == SEL_DIR_OUT && sel_idx_i == SEL_W'(1)
    && sel_val_i <= SEL_W'(NUM_OUT)) |=> out_sel_ff[1] == $past(sel_val_i))
    else $error("unlocked output selection write was lost");
  a_in_sel_lands: assert property (
    disable iff (sys_rst_i) (sel_write_ok && sel_dir_i == SEL_DIR_IN && sel_idx_i == SEL_W'(0)
    && sel_val_i < SEL_W'(NUM_PINS)) |=> in_sel_ff[0] == $past(sel_val_i))
    else $error("unlocked input selection write was lost");

  c_route_write: cover property (disable iff (sys_rst_i) sel_write_ok);
  c_locked_refuse: cover property (disable iff (sys_rst_i) locked && sel_wr_i);

endmodule : prl_router
